// ### wfmpd_defs.svh
// register offsets, field positions, reset values and counts for wake detect
`ifndef WFMPD_DEFS_SVH
`define WFMPD_DEFS_SVH

// register byte addresses
`define WFMPD_ADR_CTRL 4'h0
`define WFMPD_ADR_PORT 4'h4

// wake_control_status field positions
`define WFMPD_BIT_MAGIC_EN 1
`define WFMPD_BIT_WAKE_EN 2
`define WFMPD_BIT_MAGIC_FLAG 4
`define WFMPD_BIT_WAKE_FLAG 5
`define WFMPD_BIT_MNOT 8
`define WFMPD_BIT_MPME 9
`define WFMPD_BIT_WNOT 10
`define WFMPD_BIT_WPME 11
`define WFMPD_BIT_PCLR 16
`define WFMPD_PTR_LSB 16

// wake_filter_port word indices
`define WFMPD_WORD_CMD 3'h4
`define WFMPD_WORD_OFS 3'h5
`define WFMPD_WORD_CRC01 3'h6
`define WFMPD_WORD_CRC23 3'h7

// filter command field positions
`define WFMPD_CMD_EN 0
`define WFMPD_CMD_MCAST 3

// filter geometry and crc
`define WFMPD_NFILT 4
`define WFMPD_MASK_LEN 11'h01f
`define WFMPD_CRC_POLY 16'h8005
`define WFMPD_CRC_INIT 16'hffff

// magic packet figures
`define WFMPD_SYNC_LEN 3'h6
`define WFMPD_LAST_IDX 3'h5
`define WFMPD_LAST_COPY 4'hf
`define WFMPD_SYNC_BYTE 8'hff

// reset value of the register words
`define WFMPD_RST_WORD 32'h0000_0000

`endif

// ### wfmpd_filter.sv
// one wake-up pattern filter: masked crc-16 over a frame window
`timescale 1ns/10ps
`default_nettype none
`include "wfmpd_defs.svh"

module wfmpd_filter
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte stream
  wfmpd_rx_if.sink rx,
  // configuration
  input wire logic en_i,
  input wire logic [31:0] mask_i,
  input wire logic [3:0] cmd_i,
  input wire logic [7:0] offset_i,
  input wire logic [15:0] crc_exp_i,
  // match at the last byte
  output logic hit_o
);

  logic [15:0] crc_q;
  logic [15:0] next_crc;
  logic [15:0] base_crc;
  wire [10:0] ofs_w = {3'h0, offset_i};
  wire [10:0] rel_w = rx.pos - ofs_w;
  wire in_win_w = (rx.pos >= ofs_w) && (rel_w < `WFMPD_MASK_LEN);
  wire take_w;
  wire addr_ok_w;

  // serial crc over one byte, low bit first as on the wire
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb)
        r = r ^ `WFMPD_CRC_POLY;
    end
    return r;
  endfunction

  // R04: window starts at offset
  // R01: mask bit j picks byte
  assign take_w = in_win_w && mask_i[rel_w[4:0]];
  assign base_crc = rx.sof ? `WFMPD_CRC_INIT : crc_q;
  assign next_crc = take_w ? crc_byte(base_crc, rx.data) : base_crc;

  // R02: address type selects frames
  assign addr_ok_w = (cmd_i[`WFMPD_CMD_MCAST] == rx.mcast);

  // R03: disabled filter never matches
  // R06: compare with expected crc
  assign hit_o = rx.valid && rx.eof && en_i && cmd_i[`WFMPD_CMD_EN] &&
                 addr_ok_w && (next_crc == crc_exp_i);

  // running crc, restarted by each frame start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      crc_q <= `WFMPD_CRC_INIT;
    else if (rx.valid)
      crc_q <= next_crc;
  end

endmodule

`default_nettype wire

// ### wfmpd_magic.sv
// magic packet scanner: sync run then sixteen station address copies
`timescale 1ns/10ps
`default_nettype none
`include "wfmpd_defs.svh"

module wfmpd_magic
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte stream
  wfmpd_rx_if.sink rx,
  // configuration
  input wire logic en_i,
  input wire logic [47:0] addr_i,
  // detection pulse
  output logic hit_o
);

  wfmpd_pkg::wfmpd_magic_state_t state_q;
  wfmpd_pkg::wfmpd_magic_state_t base_state;
  wfmpd_pkg::wfmpd_magic_state_t next_state;
  logic [2:0] ff_q;
  logic [2:0] idx_q;
  logic [3:0] cp_q;
  logic [2:0] base_ff;
  logic [2:0] base_idx;
  logic [3:0] base_cp;
  logic [2:0] next_ff;
  logic [2:0] next_idx;
  logic [3:0] next_cp;
  logic found;
  wire [7:0] exp_w = addr_i[{base_idx, 3'b000} +: 8];
  wire is_ff_w = (rx.data == `WFMPD_SYNC_BYTE);

  // a new frame always restarts the search
  assign base_state = rx.sof ? wfmpd_pkg::WFMPD_SYNC : state_q;
  assign base_ff = rx.sof ? 3'h0 : ff_q;
  assign base_idx = rx.sof ? 3'h0 : idx_q;
  assign base_cp = rx.sof ? 4'h0 : cp_q;

  // scanner next state
  always_comb
  begin
    next_state = base_state;
    next_ff = base_ff;
    next_idx = base_idx;
    next_cp = base_cp;
    found = 1'b0;
    case (base_state)
      wfmpd_pkg::WFMPD_SYNC:
      begin
        // R13: copies may start anywhere, but only straight after the sync run
        if (is_ff_w)
          next_ff = (base_ff == `WFMPD_SYNC_LEN) ? base_ff : base_ff + 3'h1;
        else if (base_ff == `WFMPD_SYNC_LEN && rx.data == addr_i[7:0])
        begin
          next_state = wfmpd_pkg::WFMPD_ADDR;
          next_idx = 3'h1;
          next_cp = 4'h0;
          next_ff = 3'h0;
        end
        else
          next_ff = 3'h0;
      end
      wfmpd_pkg::WFMPD_ADDR:
      begin
        // R11: sixteen unbroken copies
        if (rx.data == exp_w)
        begin
          if (base_idx == `WFMPD_LAST_IDX)
          begin
            next_idx = 3'h0;
            next_cp = base_cp + 4'h1;
            if (base_cp == `WFMPD_LAST_COPY)
            begin
              found = 1'b1;
              next_state = wfmpd_pkg::WFMPD_SYNC;
              next_cp = 4'h0;
            end
          end
          else
            next_idx = base_idx + 3'h1;
        end
        else
        begin
          // R12: broken run, hunt sync again
          next_state = wfmpd_pkg::WFMPD_SYNC;
          next_ff = is_ff_w ? 3'h1 : 3'h0;
          next_idx = 3'h0;
          next_cp = 4'h0;
        end
      end
      default:
      begin
        next_state = wfmpd_pkg::WFMPD_SYNC;
        next_ff = 3'h0;
      end
    endcase
  end

  // R14: multicast frames qualify too
  assign hit_o = rx.valid && en_i && found;

  // scanner registers advance on each byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= wfmpd_pkg::WFMPD_SYNC;
      ff_q <= 3'h0;
      idx_q <= 3'h0;
      cp_q <= 4'h0;
    end
    else if (rx.valid)
    begin
      state_q <= next_state;
      ff_q <= next_ff;
      idx_q <= next_idx;
      cp_q <= next_cp;
    end
  end

endmodule

`default_nettype wire

// ### wfmpd_pkg.sv
// types shared by the wake detect modules
package wfmpd_pkg;

  // magic packet scanner states
  typedef enum logic [0:0]
  {
    WFMPD_SYNC,
    WFMPD_ADDR
  } wfmpd_magic_state_t;

  typedef logic [7:0] wfmpd_byte_t;

endpackage

// ### wfmpd_rx_if.sv
// receive byte stream shared by the top and its detectors
`timescale 1ns/10ps
`default_nettype none

interface wfmpd_rx_if;
  logic valid;
  logic sof;
  logic eof;
  wfmpd_pkg::wfmpd_byte_t data;
  logic [10:0] pos;
  logic mcast;

  // top drives the stream
  modport src (output valid, output sof, output eof, output data,
               output pos, output mcast);
  // detectors watch it
  modport sink (input valid, input sof, input eof, input data,
                input pos, input mcast);
endinterface

`default_nettype wire

// ### wfmpd_rx_src.sv
// mac receive path model feeding frame bytes to the detector
`timescale 1ns/10ps
`default_nettype none

module wfmpd_rx_src
(
  // clock
  input wire logic clk_i,
  // byte stream toward the detector
  output logic valid_o,
  output logic sof_o,
  output logic eof_o,
  output logic [7:0] data_o
);
  initial
  begin
    valid_o = 1'b0;
    sof_o = 1'b0;
    eof_o = 1'b0;
    data_o = 8'h00;
  end

  // idle cycles invert the data so a stale byte never looks valid
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i])
    begin
      @(posedge clk_i);
      if (i > 0 && $urandom_range(3) == 0)
      begin
        valid_o <= 1'b0;
        data_o <= ~f[i-1];
        @(posedge clk_i);
      end
      valid_o <= 1'b1;
      sof_o <= (i == 0);
      eof_o <= (i == f.size() - 1);
      data_o <= f[i];
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    sof_o <= 1'b0;
    eof_o <= 1'b0;
    data_o <= ~f[f.size()-1];
  endtask
endmodule

`default_nettype wire

// ### wfmpd_top.sv
// wake-up frame and magic packet detection with its wishbone registers
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "wfmpd_defs.svh"

// Notes on behaviour
// R01: mask bit j checks byte offset+j
// R02: address type picks multicast or unicast
// R03: command bit zero enables filter
// R04: eight-bit offset, position zero first byte
// R05: software keeps offset at least twelve
// R06: equal crc-16 means wake frame
// R07: magic enable stops normal reception
// R08: magic hit routes to irq or event
// R09: magic hit sets magic flag
// R10: clearing magic enable restores reception
// R11: sixteen consecutive address copies after sync
// R12: broken run restarts sync search
// R13: copies anywhere, sync right before
// R14: multicast frames also accepted as magic
// R15: full power needs magic enable bit
// R16: low power enables both detectors
// R17: wake enable stops normal reception
// R18: wake hit sets flag, routes notify
// R19: four filters loaded by eight writes
// R20: broadcast wake ignores broadcast disable
// R21: flags stay until software clears
module wfmpd_top
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive byte stream from the mac
  input wire logic rx_valid_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  input wire logic [7:0] rx_data_i,
  // station state
  input wire logic [47:0] station_addr_i,
  input wire logic first_low_power_state_i,
  input wire logic broadcast_disable_i,
  // results
  output logic rx_deliver_o,
  output logic host_irq_o,
  output logic power_event_out_o
);

  wfmpd_rx_if rx_bus ();

  // register words and state
  logic [31:0] word_q [8];
  logic [2:0] ptr_q;
  logic magic_detect_enable;
  logic wake_frame_detect_enable;
  logic magic_detect_flag;
  logic wake_frame_detect_flag;
  logic magic_notify;
  logic magic_to_event;
  logic wake_notify;
  logic wake_to_event;
  logic ack_q;
  logic [10:0] pos_q;
  logic mcast_q;
  logic broadcast_disable_q;
  logic [`WFMPD_NFILT-1:0] filt_hit;
  logic magic_hit;
  logic [31:0] ctrl_rd;
  logic [31:0] next_word;

  // bus decode; write lands on the edge where ack is high
  wire req_w = wb_cyc_i && wb_stb_i;
  wire take_w = req_w && !ack_q;
  wire done_w = req_w && ack_q;
  wire hit_ctrl_w = (wb_adr_i == `WFMPD_ADR_CTRL);
  wire hit_port_w = (wb_adr_i == `WFMPD_ADR_PORT);
  wire wr_ctrl_w = done_w && wb_we_i && hit_ctrl_w;
  wire wr_port_w = done_w && wb_we_i && hit_port_w;
  wire rd_port_w = done_w && !wb_we_i && hit_port_w;
  wire wr_lo_w = wr_ctrl_w && wb_sel_i[0];
  wire wr_hi_w = wr_ctrl_w && wb_sel_i[1];
  wire ptr_clr_w = wr_ctrl_w && wb_sel_i[2] && wb_dat_i[`WFMPD_BIT_PCLR];
  wire clr_magic_w = wr_lo_w && wb_dat_i[`WFMPD_BIT_MAGIC_FLAG];
  wire clr_wake_w = wr_lo_w && wb_dat_i[`WFMPD_BIT_WAKE_FLAG];

  // R15: full power only with enable bit
  // R16: low power forces both detectors on
  wire magic_on_w = magic_detect_enable || first_low_power_state_i;
  wire wake_on_w = wake_frame_detect_enable || first_low_power_state_i;

  // R07: magic mode blocks normal delivery
  // R17: wake mode blocks normal delivery
  // R10: dropping enables restores it
  wire detect_mode_w = magic_on_w || wake_on_w;
  wire broadcast_disable_drop_w = broadcast_disable_i && broadcast_disable_q;

  // R19: byte-lane merge into the selected filter word
  always_comb
  begin
    next_word = word_q[ptr_q];
    for (int b = 0; b < 4; b++)
    begin
      if (wb_sel_i[b])
        next_word[8*b +: 8] = wb_dat_i[8*b +: 8];
    end
    // R01: mask bit 31 kept at zero
    if (ptr_q < `WFMPD_WORD_CMD)
      next_word[31] = 1'b0;
  end

  // status and control read view
  assign ctrl_rd = {13'h0, ptr_q, 4'h0, wake_to_event, wake_notify,
                    magic_to_event, magic_notify, 2'h0,
                    wake_frame_detect_flag, magic_detect_flag, 1'b0,
                    wake_frame_detect_enable, magic_detect_enable, 1'b0};

  // wishbone answer one cycle after the request is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      wb_dat_o <= `WFMPD_RST_WORD;
    end
    else
    begin
      ack_q <= take_w;
      if (take_w)
        wb_dat_o <= hit_ctrl_w ? ctrl_rd :
                    hit_port_w ? word_q[ptr_q] : `WFMPD_RST_WORD;
    end
  end

  assign wb_ack_o = ack_q;

  // R19: port pointer walks the eight words
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ptr_clr_w)
      ptr_q <= 3'h0;
    else if (wr_port_w || rd_port_w)
      ptr_q <= ptr_q + 3'h1;
  end

  // filter word storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int w = 0; w < 8; w++)
        word_q[w] <= `WFMPD_RST_WORD;
    end
    else if (wr_port_w)
      word_q[ptr_q] <= next_word;
  end

  // control bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      magic_detect_enable <= 1'b0;
      wake_frame_detect_enable <= 1'b0;
      magic_notify <= 1'b0;
      magic_to_event <= 1'b0;
      wake_notify <= 1'b0;
      wake_to_event <= 1'b0;
    end
    else
    begin
      if (wr_lo_w)
      begin
        magic_detect_enable <= wb_dat_i[`WFMPD_BIT_MAGIC_EN];
        wake_frame_detect_enable <= wb_dat_i[`WFMPD_BIT_WAKE_EN];
      end
      if (wr_hi_w)
      begin
        magic_notify <= wb_dat_i[`WFMPD_BIT_MNOT];
        magic_to_event <= wb_dat_i[`WFMPD_BIT_MPME];
        wake_notify <= wb_dat_i[`WFMPD_BIT_WNOT];
        wake_to_event <= wb_dat_i[`WFMPD_BIT_WPME];
      end
    end
  end

  // sticky flags; a hit in the clearing cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      magic_detect_flag <= 1'b0;
      wake_frame_detect_flag <= 1'b0;
    end
    else
    begin
      // R09: magic hit sets flag
      // R21: held until written one
      if (magic_hit)
        magic_detect_flag <= 1'b1;
      else if (clr_magic_w)
        magic_detect_flag <= 1'b0;
      // R18: wake hit sets flag
      if (|filt_hit)
        wake_frame_detect_flag <= 1'b1;
      else if (clr_wake_w)
        wake_frame_detect_flag <= 1'b0;
    end
  end

  // frame position and destination class
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_q <= 11'h0;
      mcast_q <= 1'b0;
      broadcast_disable_q <= 1'b0;
    end
    else if (rx_valid_i)
    begin
      pos_q <= (rx_bus.pos == 11'h7ff) ? rx_bus.pos : rx_bus.pos + 11'h1;
      if (rx_sof_i)
      begin
        mcast_q <= rx_data_i[0];
        broadcast_disable_q <= (rx_data_i == `WFMPD_SYNC_BYTE);
      end
      else if (pos_q < 11'h6)
        broadcast_disable_q <= broadcast_disable_q && (rx_data_i == `WFMPD_SYNC_BYTE);
    end
  end

  // R04: first destination byte is position zero
  assign rx_bus.valid = rx_valid_i;
  assign rx_bus.sof = rx_sof_i;
  assign rx_bus.eof = rx_eof_i;
  assign rx_bus.data = rx_data_i;
  assign rx_bus.pos = rx_sof_i ? 11'h0 : pos_q;
  assign rx_bus.mcast = mcast_q;

  // four independent pattern filters
  for (genvar f = 0; f < `WFMPD_NFILT; f++)
  begin : g_filt
    // R20: broadcast disable plays no part here
    wfmpd_filter u_filt
    (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .rx (rx_bus.sink),
      .en_i (wake_on_w),
      .mask_i (word_q[f]),
      .cmd_i (word_q[`WFMPD_WORD_CMD][8*f +: 4]),
      .offset_i (word_q[`WFMPD_WORD_OFS][8*f +: 8]),
      .crc_exp_i (word_q[`WFMPD_WORD_CRC01 + f / 2][16 * (f % 2) +: 16]),
      .hit_o (filt_hit[f])
    );
  end

  // magic packet scanner
  wfmpd_magic u_magic
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .rx (rx_bus.sink),
    .en_i (magic_on_w),
    .addr_i (station_addr_i),
    .hit_o (magic_hit)
  );

  // notify lines follow the flags; route bit picks the line
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      host_irq_o <= 1'b0;
      power_event_out_o <= 1'b0;
      rx_deliver_o <= 1'b0;
    end
    else
    begin
      // R08: magic routed to irq or event
      // R18: wake routed to irq or event
      host_irq_o <= (magic_detect_flag && magic_notify && !magic_to_event) ||
                    (wake_frame_detect_flag && wake_notify && !wake_to_event);
      power_event_out_o <= (magic_detect_flag && magic_notify &&
                            magic_to_event) ||
                           (wake_frame_detect_flag && wake_notify &&
                            wake_to_event);
      rx_deliver_o <= !detect_mode_w && !broadcast_disable_drop_w;
    end
  end

endmodule

`default_nettype wire

// ### wfmpd_top_properties.sv
// concurrent checks on the wake detect top ports
`timescale 1ns/10ps
`default_nettype none

module wfmpd_props
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // stream and results
  input wire logic rx_valid_i,
  input wire logic first_low_power_state_i,
  input wire logic rx_deliver_o,
  input wire logic host_irq_o,
  input wire logic power_event_out_o
);
  logic [3:0] seen_rx;
  logic [3:0] seen_wr;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // recent bytes and writes: the only lawful causes of a notify edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seen_rx <= 4'h0;
      seen_wr <= 4'h0;
    end
    else
    begin
      seen_rx <= {seen_rx[2:0], rx_valid_i};
      seen_wr <= {seen_wr[2:0], wb_ack_o & wb_we_i};
    end
  end

  a_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no acknowledge one cycle after a request");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_cause:
    assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("acknowledge without a request");
  a_reset_quiet:
    assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0 &&
      !host_irq_o && !power_event_out_o && !rx_deliver_o)
    else $error("outputs not cleared by reset");
  a_low_power_mute:
    assert property (first_low_power_state_i [*2] |-> !rx_deliver_o)
    else $error("normal reception left on in low power");
  a_irq_cause:
    assert property ($rose(host_irq_o) |-> (|seen_rx) || (|seen_wr))
    else $error("interrupt rose with no byte or write");
  a_irq_hold:
    assert property ($fell(host_irq_o) |-> |seen_wr)
    else $error("interrupt dropped without a clearing write");
  a_event_cause:
    assert property ($rose(power_event_out_o) |-> (|seen_rx) || (|seen_wr))
    else $error("power event rose with no byte or write");
  a_event_hold:
    assert property ($fell(power_event_out_o) |-> |seen_wr)
    else $error("power event dropped without a clearing write");
endmodule

bind wfmpd_top wfmpd_props u_props
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rx_valid_i(rx_valid_i), .first_low_power_state_i(first_low_power_state_i),
  .rx_deliver_o(rx_deliver_o), .host_irq_o(host_irq_o),
  .power_event_out_o(power_event_out_o)
);

`default_nettype wire

// ### wfmpd_top_tb.sv
// self-checking bench for the wake frame and magic packet detector
`timescale 1ns/10ps
`default_nettype none
`include "wfmpd_defs.svh"

module wfmpd_top_tb;
  logic clk_i, rst_i, cyc, stb, we, lp, bdis, mc, exp_flag, mflag;
  logic [3:0] adr;
  logic [31:0] wdat, rd;
  logic [47:0] sta;
  logic [7:0] fr[$];
  logic [31:0] mask[4];
  logic [3:0] cmd[4];
  logic [7:0] ofs[4];
  logic [15:0] crc[4];
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, rx_valid, rx_sof, rx_eof, deliver, irq, pwr_event;
  wire logic [7:0] rx_data;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  wfmpd_rx_src src (.clk_i(clk_i), .valid_o(rx_valid), .sof_o(rx_sof),
    .eof_o(rx_eof), .data_o(rx_data));
  wfmpd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid), .rx_sof_i(rx_sof), .rx_eof_i(rx_eof),
    .rx_data_i(rx_data), .station_addr_i(sta),
    .first_low_power_state_i(lp), .broadcast_disable_i(bdis),
    .rx_deliver_o(deliver), .host_irq_o(irq), .power_event_out_o(pwr_event));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard, well above the two thousand or so cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // no cycle count assumed: only the hang guard ends this wait
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // header, optional broken run, sync then address copies, tail
  task automatic mk_magic(input logic m, input int brk, input int copies);
    fr = {};
    repeat (20) fr.push_back(8'($urandom) & 8'h7e);
    fr[0][0] = m;
    for (int r = 0; r < 2; r++)
    begin
      repeat (6) fr.push_back(8'hff);
      for (int k = 0; k < 6 * (r == 0 ? brk : copies); k++)
        fr.push_back(sta[8*(k%6) +: 8]);
      if (r == 0)
        fr.push_back(8'h5a);
    end
    repeat (4) fr.push_back(8'($urandom) & 8'h7e);
  endtask

  // scanner model: six or more all-ones bytes, then 96 address bytes
  function automatic logic magic_model();
    int ff = 0;
    int k = -1;
    foreach (fr[i])
    begin
      if (k >= 0 && fr[i] === sta[8*(k%6) +: 8])
      begin
        k++;
        // a run of copies is no sync stream
        ff = 0;
        if (k == 96)
          return 1'b1;
      end
      else
      begin
        k = (ff >= 6 && fr[i] === sta[7:0]) ? 1 : -1;
        ff = (fr[i] === 8'hff) ? ff + 1 : 0;
      end
    end
    return 1'b0;
  endfunction

  // crc-16 0x8005, init all ones, lsb of each masked byte first
  function automatic logic [15:0] crc_model(input logic [30:0] m,
    input logic [7:0] o);
    logic [15:0] c = 16'hffff;
    for (int j = 0; j < 31; j++)
      if (m[j])
        for (int b = 0; b < 8; b++)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[o+j][b]) ? 16'h8005 : 16'h0);
    return c;
  endfunction

  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    lp = 1'b0;
    bdis = 1'b0;
    rst_i = 1'b1;
    void'($urandom(6));
    sta = {16'($urandom), $urandom};
    sta[0] = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, `WFMPD_ADR_CTRL, 32'h0);
    chk("control reset", rd, 32'h0);
    bus(1, 4'hc, 32'hffff_ffff);
    bus(0, 4'hc, 32'h0);
    chk("unmapped read", rd, 32'h0);
    $display("test registers done");
    // magic enable with irq notify; flags accumulate until cleared
    bus(1, `WFMPD_ADR_CTRL, 32'h0000_0102);
    idle(2);
    chk("deliver in magic mode", deliver, 1'b0);
    mflag = 1'b0;
    for (int t = 0; t < 4; t++)
    begin
      mk_magic(t == 3, t == 1 ? 5 : 0, t == 0 ? 15 : (t == 2 ? 0 : 16));
      mflag |= magic_model();
      src.send(fr);
      idle(4);
      bus(0, `WFMPD_ADR_CTRL, 32'h0);
      chk("magic flag", rd[4], mflag);
      chk("magic irq", irq, mflag);
      // clear once so the last, multicast frame must set it afresh
      if (t == 2)
      begin
        bus(1, `WFMPD_ADR_CTRL, 32'h0000_0112);
        mflag = 1'b0;
      end
    end
    bus(1, `WFMPD_ADR_CTRL, 32'h0000_0010);
    idle(3);
    chk("irq after clear", irq, 1'b0);
    chk("deliver restored", deliver, 1'b1);
    $display("test magic done");
    for (int n = 0; n < 6; n++)
    begin
      fr = {};
      repeat (64) fr.push_back(8'($urandom));
      mc = 1'($urandom);
      if (n == 4)
      begin
        for (int i = 0; i < 6; i++)
          fr[i] = 8'hff;
        bdis <= 1'b1;
      end
      mc = (n == 4) ? 1'b1 : mc;
      fr[0][0] = mc;
      exp_flag = 1'b0;
      // wake enable to power event, port pointer back to word zero
      bus(1, `WFMPD_ADR_CTRL, 32'h0001_0c04);
      for (int f = 0; f < 4; f++)
      begin
        mask[f] = $urandom;
        cmd[f] = 4'($urandom) & 4'h9;
        if (f == 0 && n % 2 == 0)
          cmd[f] = {mc, 3'h1};
        ofs[f] = 8'h0c + 8'($urandom % 20);
        crc[f] = crc_model(mask[f][30:0], ofs[f]);
        if (f > 0 || n % 2 == 1)
          crc[f] = crc[f] ^ 16'($urandom % 2);
        exp_flag |= cmd[f][0] && cmd[f][3] === mc &&
          crc[f] === crc_model(mask[f][30:0], ofs[f]);
        bus(1, `WFMPD_ADR_PORT, mask[f]);
      end
      bus(1, `WFMPD_ADR_PORT, {4'h0, cmd[3], 4'h0, cmd[2], 4'h0, cmd[1],
        4'h0, cmd[0]});
      bus(1, `WFMPD_ADR_PORT, {ofs[3], ofs[2], ofs[1], ofs[0]});
      bus(1, `WFMPD_ADR_PORT, {crc[1], crc[0]});
      bus(1, `WFMPD_ADR_PORT, {crc[3], crc[2]});
      bus(0, `WFMPD_ADR_PORT, 32'h0);
      chk("mask word", rd, mask[0] & 32'h7fff_ffff);
      chk("deliver in wake mode", deliver, 1'b0);
      src.send(fr);
      idle(4);
      bus(0, `WFMPD_ADR_CTRL, 32'h0);
      chk("wake flag", rd[5], exp_flag);
      chk("wake event", pwr_event, exp_flag);
      bus(1, `WFMPD_ADR_CTRL, 32'h0000_0c24);
      bdis <= 1'b0;
      idle(3);
    end
    $display("test wake done");
    bus(1, `WFMPD_ADR_CTRL, 32'h0000_0100);
    // full power with the enable bit clear must ignore a magic packet
    mk_magic(1'b0, 0, 16);
    src.send(fr);
    idle(4);
    bus(0, `WFMPD_ADR_CTRL, 32'h0);
    chk("magic without enable", rd[4], 1'b0);
    lp <= 1'b1;
    idle(3);
    chk("deliver in low power", deliver, 1'b0);
    mk_magic(1'b0, 0, 16);
    src.send(fr);
    idle(4);
    bus(0, `WFMPD_ADR_CTRL, 32'h0);
    chk("low power magic", rd[4], 1'b1);
    chk("low power irq", irq, 1'b1);
    lp <= 1'b0;
    $display("test low power done");
    end_of_test();
  end
endmodule

`default_nettype wire
